// [logic/fps_top.sv]
// Purpose: phase sequencer and status registers of the floppy controller
// Assumes: host port reg_rd/reg_wr one-cycle strobes, drive events as pulses
// Notes: drive-side data bytes pass a two-entry buffer; reads return registered data next cycle
`timescale 1ns/1ps
module fps_top (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic media_change_input_n,
    input wire logic track_zero_input_n,
    input wire logic terminal_count,
    input wire logic drv_valid,
    input wire logic [7:0] drv_data,
    output logic drv_ready,
    input wire logic exec_done,
    input wire logic ev_crc,
    input wire logic ev_overrun,
    input wire logic ev_no_data,
    input wire logic ev_write_prot,
    input wire logic ev_absent_id,
    input wire logic ev_end_track,
    input wire logic ev_poll_err,
    input wire logic head_sel,
    input wire logic drive_sel,
    output logic [1:0] transfer_rate_field,
    output logic fifo_enabled,
    output logic host_interrupt,
    output logic dma_request
);
    typedef struct packed {
        fps_pkg::fps_phase_t phase;
        logic req;
        logic dir;
        logic busy;
        logic non_dma;
        logic fifo_en;
        logic [1:0] rate;
        logic [3:0] op;
        logic [3:0] left;
        logic [3:0] res_left;
        logic [2:0] res_idx;
        fps_pkg::fps_st0_t st0;
        logic [7:0] st1;
        logic [7:0] rdata;
        logic irq;
        logic drq;
        logic drv_rdy;
        logic [1:0] chg_sync;
        logic [1:0] trk_sync;
    } fps_state_t;

    fps_state_t s_q, s_d;
    fps_buf_if bi();
    logic data_rd, data_wr, pop_byte, trk_seen;

    fps_skid u_skid (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .b(bi.buffer)
    );

    // ----------------------------------------
    // Opcode table
    // ----------------------------------------
    function automatic logic [3:0] param_count(input logic [3:0] op);
        case (op)
            fps_pkg::OP_READ, fps_pkg::OP_WRITE: param_count = fps_pkg::PAR_RW;
            fps_pkg::OP_SPECIFY: param_count = fps_pkg::PAR_SPECIFY;
            fps_pkg::OP_SEEK: param_count = fps_pkg::PAR_SEEK;
            fps_pkg::OP_RECAL: param_count = fps_pkg::PAR_RECAL;
            default: param_count = fps_pkg::LEN_ZERO;
        endcase
    endfunction

    function automatic logic [3:0] result_count(input logic [3:0] op);
        case (op)
            fps_pkg::OP_READ, fps_pkg::OP_WRITE: result_count = fps_pkg::RES_FULL;
            fps_pkg::OP_SENSE: result_count = fps_pkg::RES_SENSE;
            fps_pkg::OP_SPECIFY, fps_pkg::OP_SEEK, fps_pkg::OP_RECAL: result_count = fps_pkg::LEN_ZERO;
            default: result_count = fps_pkg::LEN_ONE;
        endcase
    endfunction

    function automatic logic valid_op(input logic [3:0] op);
        valid_op = (param_count(op) != fps_pkg::LEN_ZERO) || (op == fps_pkg::OP_SENSE);
    endfunction

    function automatic logic has_exec(input logic [3:0] op);
        has_exec = (op == fps_pkg::OP_READ) || (op == fps_pkg::OP_WRITE) || (op == fps_pkg::OP_SEEK)
            || (op == fps_pkg::OP_RECAL);
    endfunction

    assign data_wr = reg_wr && (reg_addr == fps_pkg::OFS_DATA);
    assign data_rd = reg_rd && (reg_addr == fps_pkg::OFS_DATA);
    assign bi.in_valid = drv_valid;
    assign bi.in_data = drv_data;
    // Host drains the buffer only in execution; a slow host stalls the drive side
    assign pop_byte = data_rd && (s_q.phase == fps_pkg::PH_EXEC) && s_q.dir;
    assign bi.out_ready = pop_byte;
    assign trk_seen = !s_q.trk_sync[1];

    always_comb
    begin
        s_d = s_q;
        s_d.chg_sync = {s_q.chg_sync[0], media_change_input_n};
        s_d.trk_sync = {s_q.trk_sync[0], track_zero_input_n};
        s_d.drv_rdy = bi.in_ready;
        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        if (reg_rd)
        begin
            case (reg_addr)
                fps_pkg::OFS_DISK_CHANGE: s_d.rdata = {~s_q.chg_sync[1], 7'h00};
                fps_pkg::OFS_MAIN_STATUS: s_d.rdata = {s_q.req, s_q.dir, s_q.non_dma, s_q.busy, 4'h0};
                fps_pkg::OFS_DATA:
                begin
                    if (s_q.phase == fps_pkg::PH_RESULT)
                    begin
                        case (s_q.res_idx)
                            // Bit 3 unused, reads zero
                            3'h0: s_d.rdata = {s_q.st0.code, s_q.st0.seek_end, s_q.st0.track_fault, 1'b0,
                                s_q.st0.head, s_q.st0.drv1, s_q.st0.drv0};
                            3'h1: s_d.rdata = s_q.st1;
                            default: s_d.rdata = 8'h00;
                        endcase
                    end
                    else
                        s_d.rdata = bi.out_data;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end
        // ----------------------------------------
        // Rate writes, latest wins
        // ----------------------------------------
        if (reg_wr && (reg_addr == fps_pkg::OFS_DISK_CHANGE || reg_addr == fps_pkg::OFS_RATE_SELECT))
            s_d.rate = reg_wdata[1:0];
        // ----------------------------------------
        // Phase sequencing
        // ----------------------------------------
        case (s_q.phase)
            fps_pkg::PH_COMMAND:
            begin
                if (data_wr && s_q.req && !s_q.dir)
                begin
                    s_d.req = 1'b0;
                    s_d.busy = 1'b1;
                    if (!s_q.busy)
                    begin
                        s_d.op = reg_wdata[3:0];
                        s_d.left = param_count(reg_wdata[3:0]);
                        s_d.st0 = '0;
                        s_d.st1 = 8'h00;
                        s_d.st0.head = head_sel;
                        s_d.st0.drv1 = drive_sel;
                        s_d.st0.drv0 = !drive_sel;
                        if (!valid_op(reg_wdata[3:0]))
                            s_d.st0.code = fps_pkg::CC_INVALID;
                    end
                    else
                    begin
                        s_d.left = s_q.left - 4'h1;
                        if (s_q.op == fps_pkg::OP_SPECIFY && s_q.left == fps_pkg::LEN_ONE)
                            s_d.non_dma = reg_wdata[0];
                    end
                end
                else if (s_q.busy && !s_q.req)
                begin
                    if (s_q.left != fps_pkg::LEN_ZERO)
                        s_d.req = 1'b1;
                    else
                    begin
                        s_d.fifo_en = 1'b0;
                        s_d.res_idx = 3'h0;
                        s_d.res_left = result_count(s_q.op);
                        if (has_exec(s_q.op))
                        begin
                            s_d.phase = fps_pkg::PH_EXEC;
                            s_d.dir = (s_q.op == fps_pkg::OP_READ);
                        end
                        else if (result_count(s_q.op) != fps_pkg::LEN_ZERO)
                        begin
                            s_d.phase = fps_pkg::PH_RESULT;
                            s_d.req = 1'b1;
                            s_d.dir = 1'b1;
                            s_d.irq = 1'b1;
                        end
                        else
                        begin
                            s_d.req = 1'b1;
                            s_d.busy = 1'b0;
                            s_d.fifo_en = 1'b1;
                        end
                    end
                end
            end
            fps_pkg::PH_EXEC:
            begin
                // Pacing: reads request while a byte is available; writes hold request high
                s_d.req = s_q.dir ? bi.out_valid : 1'b1;
                s_d.irq = s_q.non_dma && bi.out_valid;
                s_d.drq = !s_q.non_dma && bi.out_valid;
                if (ev_crc)
                    s_d.st1[5] = 1'b1;
                if (ev_overrun)
                    s_d.st1[4] = 1'b1;
                if (ev_no_data)
                    s_d.st1[2] = 1'b1;
                if (ev_write_prot)
                    s_d.st1[1] = 1'b1;
                if (ev_absent_id)
                    s_d.st1[0] = 1'b1;
                if (ev_end_track)
                    s_d.st1[7] = 1'b1;
                if (exec_done)
                begin
                    s_d.drq = 1'b0;
                    if ((s_q.op == fps_pkg::OP_READ || s_q.op == fps_pkg::OP_WRITE) && !terminal_count)
                        s_d.st1[7] = 1'b1;
                    if (s_q.op == fps_pkg::OP_SEEK || s_q.op == fps_pkg::OP_RECAL)
                        s_d.st0.seek_end = 1'b1;
                    if (s_q.op == fps_pkg::OP_RECAL && !trk_seen)
                    begin
                        s_d.st0.track_fault = 1'b1;
                        s_d.st0.code = fps_pkg::CC_FAILED;
                    end
                    if (ev_poll_err)
                        s_d.st0.code = fps_pkg::CC_POLL;
                    else if (ev_crc || ev_overrun || ev_no_data || ev_write_prot || ev_absent_id
                        || s_q.st1 != 8'h00)
                        s_d.st0.code = fps_pkg::CC_FAILED;
                    if (s_q.res_left != fps_pkg::LEN_ZERO)
                    begin
                        s_d.phase = fps_pkg::PH_RESULT;
                        s_d.req = 1'b1;
                        s_d.dir = 1'b1;
                        s_d.irq = 1'b1;
                    end
                    else
                    begin
                        s_d.phase = fps_pkg::PH_COMMAND;
                        s_d.fifo_en = 1'b1;
                        s_d.req = 1'b1;
                        s_d.dir = 1'b0;
                        s_d.busy = 1'b0;
                        s_d.irq = 1'b1;
                    end
                end
            end
            fps_pkg::PH_RESULT:
            begin
                if (data_rd && s_q.req && s_q.dir)
                begin
                    s_d.irq = 1'b0;
                    s_d.res_idx = s_q.res_idx + 3'h1;
                    s_d.res_left = s_q.res_left - 4'h1;
                    if (s_q.res_left == fps_pkg::LEN_ONE)
                    begin
                        s_d.phase = fps_pkg::PH_COMMAND;
                        s_d.req = 1'b1;
                        s_d.dir = 1'b0;
                        s_d.busy = 1'b0;
                        s_d.fifo_en = 1'b1;
                    end
                end
            end
            default: s_d.phase = fps_pkg::PH_COMMAND;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.phase <= fps_pkg::PH_COMMAND;
            s_q.req <= 1'b1;
            s_q.fifo_en <= 1'b1;
            s_q.rate <= fps_pkg::RATE_RESET;
            s_q.chg_sync <= 2'h3;
            s_q.trk_sync <= 2'h3;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata = s_q.rdata;
    assign transfer_rate_field = s_q.rate;
    assign fifo_enabled = s_q.fifo_en;
    assign host_interrupt = s_q.irq;
    assign dma_request = s_q.drq;
    assign drv_ready = s_q.drv_rdy;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_rate_write;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_wr && reg_addr == fps_pkg::OFS_DISK_CHANGE |=> transfer_rate_field == $past(reg_wdata[1:0]);
    endproperty
    a_rate_write: assert property (p_rate_write) else $error("rate not taken");

    property p_req_drop;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.phase == fps_pkg::PH_COMMAND && data_wr && s_q.req && !s_q.dir |=> !s_q.req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request stayed high");

    property p_result_end;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.phase == fps_pkg::PH_RESULT && data_rd && s_q.req && s_q.res_left == fps_pkg::LEN_ONE
        |=> s_q.req && !s_q.dir && !s_q.busy;
    endproperty
    a_result_end: assert property (p_result_end) else $error("bad end of result");

    property p_result_dir;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.phase == fps_pkg::PH_RESULT |-> s_q.dir && s_q.busy;
    endproperty
    a_result_dir: assert property (p_result_dir) else $error("result flags wrong");

    property p_change_bit;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_addr == fps_pkg::OFS_DISK_CHANGE ##1 1'b1
        |-> reg_rdata[fps_pkg::BIT_CHANGED] == !$past(s_q.chg_sync[1]) && reg_rdata[6:0] == 7'h00;
    endproperty
    a_change_bit: assert property (p_change_bit) else $error("disk change read wrong");

    property p_cmd_dir;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.phase == fps_pkg::PH_COMMAND |-> !s_q.dir;
    endproperty
    a_cmd_dir: assert property (p_cmd_dir) else $error("direction set in command phase");

    property p_fifo_off;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.phase == fps_pkg::PH_COMMAND ##1 s_q.phase == fps_pkg::PH_EXEC |-> !fifo_enabled;
    endproperty
    a_fifo_off: assert property (p_fifo_off) else $error("fifo left on");

    property p_crc_flag;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.phase == fps_pkg::PH_EXEC && ev_crc |=> s_q.st1[5];
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("crc flag missed");
endmodule

// [logic/fps_pkg.sv]
// Purpose: constants and types for the floppy phase sequencer and status block
// Assumes: 8-bit host port with a 3-bit register offset, one clock
// Notes: the command table is a small stand-in, sized per opcode
package fps_pkg;
    localparam logic [2:0] OFS_RATE_SELECT = 3'h4;
    localparam logic [2:0] OFS_MAIN_STATUS = 3'h4;
    localparam logic [2:0] OFS_DATA = 3'h5;
    localparam logic [2:0] OFS_DISK_CHANGE = 3'h7;
    localparam int BIT_REQ = 7;
    localparam int BIT_DIR = 6;
    localparam int BIT_NON_DMA = 5;
    localparam int BIT_BUSY = 4;
    localparam int BIT_CHANGED = 7;
    localparam logic [1:0] RATE_RESET = 2'h2;
    localparam logic [1:0] CC_NORMAL = 2'h0;
    localparam logic [1:0] CC_FAILED = 2'h1;
    localparam logic [1:0] CC_INVALID = 2'h2;
    localparam logic [1:0] CC_POLL = 2'h3;
    localparam logic [3:0] OP_SPECIFY = 4'h3;
    localparam logic [3:0] OP_RECAL = 4'h7;
    localparam logic [3:0] OP_SEEK = 4'hf;
    localparam logic [3:0] OP_READ = 4'h6;
    localparam logic [3:0] OP_WRITE = 4'h5;
    localparam logic [3:0] OP_SENSE = 4'h8;
    localparam logic [3:0] RES_FULL = 4'h7;
    localparam logic [3:0] RES_SENSE = 4'h2;
    localparam logic [3:0] LEN_ZERO = 4'h0;
    localparam logic [3:0] LEN_ONE = 4'h1;
    localparam logic [3:0] PAR_RW = 4'h8;
    localparam logic [3:0] PAR_SPECIFY = 4'h2;
    localparam logic [3:0] PAR_SEEK = 4'h2;
    localparam logic [3:0] PAR_RECAL = 4'h1;

    typedef enum logic [1:0] {PH_COMMAND, PH_EXEC, PH_RESULT} fps_phase_t;

    typedef struct packed {
        logic [1:0] code;
        logic seek_end;
        logic track_fault;
        logic head;
        logic drv1;
        logic drv0;
    } fps_st0_t;
endpackage

// [logic/fps_buf_if.sv]
// Purpose: valid/ready carrier for execution data bytes
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
interface fps_buf_if;
    logic in_valid;
    logic in_ready;
    logic [7:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [7:0] out_data;
    modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// [logic/fps_skid.sv]
// Purpose: two-entry buffer for execution data
// Assumes: one clock, synchronous active-low reset
// Notes: in_ready reflects a free slot, so a drain stall loses nothing
`timescale 1ns/1ps
module fps_skid (
    input wire logic sys_clk,
    input wire logic rst_n,
    fps_buf_if.buffer b
);
    typedef struct packed {
        logic [1:0][7:0] mem;
        logic [1:0] cnt;
        logic wp;
        logic rp;
    } fps_skid_t;
    fps_skid_t s_q, s_d;
    logic push, pop;

    assign b.in_ready = (s_q.cnt != 2'h2);
    assign b.out_valid = (s_q.cnt != 2'h0);
    assign b.out_data = s_q.mem[s_q.rp];
    assign push = b.in_valid && b.in_ready;
    assign pop = b.out_valid && b.out_ready;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = b.in_data;
            s_d.wp = ~s_q.wp;
        end
        if (pop)
            s_d.rp = ~s_q.rp;
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule

// [testbench/fps_drive_model.sv]
// Purpose: drive-side byte source for the execution data path
// Assumes: drv_ready sampled at the rising edge, one clock
// Notes: sends two bytes per start pulse, within buffer depth
`timescale 1ns/1ps
module fps_drive_model (
    input wire logic sys_clk,
    input wire logic start,
    input wire logic drv_ready,
    output logic drv_valid,
    output logic [7:0] drv_data,
    output logic stalled
);
    int n;

    initial
    begin
        drv_valid = 1'b0;
        drv_data = 8'h00;
        stalled = 1'b0;
    end

    // Valid and data held until the edge that sees ready
    always
    begin
        @(posedge sys_clk iff start);
        for (int i = 0; i < 2; i++)
        begin
            #1 drv_valid = 1'b1;
            drv_data = 8'h5a + 8'(i);
            n = 0;
            do
            begin
                @(posedge sys_clk);
                n++;
            end
            while (!drv_ready && n < 100);
            if (!drv_ready)
                stalled = 1'b1;
        end
        #1 drv_valid = 1'b0;
        // Released bus shows no stale byte
        drv_data = ~drv_data;
    end
endmodule

// [testbench/testbench.sv]
// Purpose: self-checking bench for the phase sequencer and status block
// Assumes: host strobes driven 1 ns after the rising edge
// Notes: event pulses and exec_done stand in for the drive engine
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic mc_n = 1'b1;
    logic tz_n = 1'b1;
    logic tc = 1'b0;
    logic exec_done = 1'b0;
    logic [5:0] ev = 6'h00;
    logic poll_err = 1'b0;
    logic head_sel = 1'b1;
    logic drive_sel = 1'b1;
    logic drv_start = 1'b0;
    logic drv_valid, drv_ready, fifo_enabled, host_interrupt, dma_request;
    logic [7:0] drv_data;
    logic drv_stalled;
    logic [1:0] rate;
    logic [7:0] d;
    int err_count = 0;
    int num_checks = 0;

    always #20 sys_clk = ~sys_clk;

    fps_top fps_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .media_change_input_n(mc_n),
        .track_zero_input_n(tz_n), .terminal_count(tc), .drv_valid(drv_valid), .drv_data(drv_data),
        .drv_ready(drv_ready), .exec_done(exec_done), .ev_crc(ev[0]), .ev_overrun(ev[1]),
        .ev_no_data(ev[2]), .ev_write_prot(ev[3]), .ev_absent_id(ev[4]), .ev_end_track(ev[5]),
        .ev_poll_err(poll_err), .head_sel(head_sel), .drive_sel(drive_sel),
        .transfer_rate_field(rate), .fifo_enabled(fifo_enabled), .host_interrupt(host_interrupt),
        .dma_request(dma_request));

    fps_drive_model fps_drive_model_i (.sys_clk(sys_clk), .start(drv_start), .drv_ready(drv_ready),
        .drv_valid(drv_valid), .drv_data(drv_data), .stalled(drv_stalled));

    // ----------------------------------------
    // Host access tasks
    // ----------------------------------------
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Idle cycle after each strobe, so no strobe is set twice in one step
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        tick();
        v = reg_rdata;
    endtask

    task automatic wait_req(input logic dir);
        logic [7:0] s;
        for (int i = 0; i < 60; i++)
        begin
            rd_reg(fps_pkg::OFS_MAIN_STATUS, s);
            if (s[7] === 1'b1 && s[6] === dir)
                return;
        end
        err_count++;
        report_and_stop();
    endtask

    task automatic send(input logic [7:0] q[$]);
        foreach (q[i])
        begin
            wait_req(1'b0);
            wr_reg(fps_pkg::OFS_DATA, q[i]);
        end
    endtask

    task automatic pulse_done();
        exec_done = 1'b1;
        tick();
        exec_done = 1'b0;
        tick();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
        chk8(d, 8'h80);
        chk8({6'h00, rate}, {6'h00, fps_pkg::RATE_RESET});
        // Media change held during rate writes: each read must still show bit 7 set
        mc_n = 1'b0;
        repeat (3) tick();
        for (int r = 0; r < 4; r++)
        begin
            wr_reg(fps_pkg::OFS_DISK_CHANGE, {6'h00, 2'(r)});
            chk8({6'h00, rate}, {6'h00, 2'(r)});
            rd_reg(fps_pkg::OFS_DISK_CHANGE, d);
            chk8({d[7], 7'h00}, 8'h80);
        end
        mc_n = 1'b1;
        repeat (3) tick();
        rd_reg(fps_pkg::OFS_DISK_CHANGE, d);
        chk8({d[7], 7'h00}, 8'h00);
        wr_reg(fps_pkg::OFS_RATE_SELECT, 8'h01);
        chk8({6'h00, rate}, 8'h01);
        wr_reg(fps_pkg::OFS_DISK_CHANGE, 8'h00);
        chk8({6'h00, rate}, 8'h00);
        // Sense: command then result, no execution
        send('{8'h08});
        wait_req(1'b1);
        rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
        chk8(d, 8'hd0);
        chk8({7'h00, host_interrupt}, 8'h01);
        rd_reg(fps_pkg::OFS_DATA, d);
        chk8(d, 8'h06);
        rd_reg(fps_pkg::OFS_DATA, d);
        chk8(d, 8'h00);
        rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
        chk8(d, 8'h80);
        // Unknown opcode gives a single result byte
        send('{8'h0e});
        wait_req(1'b1);
        rd_reg(fps_pkg::OFS_DATA, d);
        chk8({d[7:6], 6'h00}, {fps_pkg::CC_INVALID, 6'h00});
        rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
        chk8(d, 8'h80);
        // Specify both modes; status bit 5 follows the last parameter
        for (int p = 1; p >= 0; p--)
        begin
            send('{8'h03, 8'h11, 8'(p)});
            rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
            chk8(d, {2'b10, 1'(p), 5'h00});
        end
        // Write data with every fault event except end of track and poll error, and no terminal count
        head_sel = 1'b0;
        drive_sel = 1'b0;
        send('{8'h05, 8'h00, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff, 8'h00});
        chk8({7'h00, fifo_enabled}, 8'h00);
        rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
        chk8({3'h0, d[4], 4'h0}, 8'h10);
        ev = 6'h1f;
        tick();
        ev = 6'h00;
        repeat (6) tick();
        chk8({7'h00, dma_request}, 8'h00);
        pulse_done();
        wait_req(1'b1);
        rd_reg(fps_pkg::OFS_DATA, d);
        chk8(d, 8'h41);
        rd_reg(fps_pkg::OFS_DATA, d);
        chk8(d, 8'hb7);
        for (int i = 0; i < 5; i++)
        begin
            rd_reg(fps_pkg::OFS_DATA, d);
            chk8(d, 8'h00);
        end
        rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
        chk8(d, 8'h80);
        // Read data: drive bytes drained by the host, terminal count given
        send('{8'h06, 8'h00, 8'h00, 8'h01, 8'h02, 8'h09, 8'h1b, 8'hff, 8'h00});
        drv_start = 1'b1;
        tick();
        drv_start = 1'b0;
        repeat (4) tick();
        chk8({6'h00, drv_ready, dma_request}, 8'h01);
        rd_reg(fps_pkg::OFS_DATA, d);
        chk8(d, 8'h5a);
        rd_reg(fps_pkg::OFS_DATA, d);
        chk8(d, 8'h5b);
        chk8({6'h00, drv_ready, dma_request}, 8'h02);
        tc = 1'b1;
        pulse_done();
        tc = 1'b0;
        wait_req(1'b1);
        for (int i = 0; i < 7; i++)
        begin
            rd_reg(fps_pkg::OFS_DATA, d);
            chk8(d, (i == 0) ? 8'h01 : 8'h00);
        end
        chk8({7'h00, drv_stalled}, 8'h00);
        // Recalibrate has no result phase
        send('{8'h07, 8'h00});
        pulse_done();
        wait_req(1'b0);
        rd_reg(fps_pkg::OFS_MAIN_STATUS, d);
        chk8(d, 8'h80);
        chk8({6'h00, fifo_enabled, host_interrupt}, 8'h03);
        report_and_stop();
    end
endmodule
